// ---- include/rtcif_pkg.sv ----
// Package for the interrupt, flag and power-up default logic.
// Assumes a single 25 MHz clock domain and a byte-wide register port.
package rtcif_pkg;

    // Register addresses on the 15-bit device address bus
    localparam logic [14:0] ADDR_EVENT_FLAGS = 15'h7ff0;
    localparam logic [14:0] ADDR_ALARM_EN = 15'h7ff6;
    localparam logic [14:0] ADDR_TIMEOUT_CTRL = 15'h7ff7;
    localparam logic [14:0] ADDR_MODE_CTRL = 15'h7ffc;

    // Flag register bit positions
    localparam int FLAG_DOG_BIT = 7;
    localparam int FLAG_ALARM_BIT = 6;
    localparam int FLAG_BATT_BIT = 4;

    // Control bit positions
    localparam int ALARM_IRQ_EN_BIT = 7;
    localparam int ALARM_BACKUP_EN_BIT = 5;
    localparam int STEER_BIT = 7;
    localparam int FTEST_BIT = 6;
    localparam int WRITE_HOLD_BIT = 7;
    localparam int READ_HOLD_BIT = 6;

    // Reset and cleared values
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic ENABLE_KEPT = 1'b1;

    // Clock and qualified-read time
    localparam int CLK_PERIOD_NS = 40;
    localparam int READ_STABLE_NS = 15;
    localparam int READ_STABLE_CYC =
        (READ_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] READ_CNT_MAX = 4'(READ_STABLE_CYC);

    // Test toggle divider (half period in clock cycles)
    localparam logic [15:0] FTEST_HALF_CYC = 16'h5f5e;

    // Supply state from the power monitor
    typedef struct packed {
        logic supply_ok;
        logic battery_attach;
        logic battery_bad;
    } rtcif_power_t;

    // Power-state tracking states
    typedef enum logic [2:0] {
        PWR_DOWN = 3'b001,
        PWR_TEST = 3'b010,
        PWR_RUN = 3'b100
    } rtcif_pwr_state_t;

endpackage : rtcif_pkg

// ---- rtl/rtcif_sync.sv ----
// Two flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes the first stage is read only by the second.
`timescale 1ns/100ps
module rtcif_sync #(
    parameter int WIDTH = 1
) (
    // Clock
    input wire logic ref_clk,
    input wire logic clk_en,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_reg;

    // Two stages, frozen with the clock enable
    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end
endmodule : rtcif_sync

// ---- rtl/rtcif_top.sv ----
// Interrupt flags, pin routing and power-up defaults.
// Assumes a host on an async SRAM-like bus and an analog power monitor.
`timescale 1ns/100ps
module rtcif_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Host bus (asynchronous pins)
    input wire logic [14:0] addr,
    input wire logic chip_en_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic rdata_oe_n,
    // Events and power monitor (asynchronous)
    input wire logic alarm_event,
    input wire logic dog_timeout,
    input wire rtcif_pkg::rtcif_power_t power,
    // Shared open-drain interrupt/test pin and reset request
    output logic interrupt_test_pin_o,
    output logic interrupt_test_pin_oe_n,
    output logic dog_reset_pulse
);
    ////////////////////////////////////////////////////////////////////
    logic [30:0] raw_in;
    logic [30:0] syn;
    logic [7:0] w_s;
    logic [14:0] a_s;
    logic ce_s, oe_s, we_s, alarm_s, dog_s;
    rtcif_pkg::rtcif_power_t pw_s;

    assign raw_in = {addr, chip_en_n, out_en_n, write_en_n, alarm_event,
                     dog_timeout, wdata, power};

    rtcif_sync #(.WIDTH(31)) u_sync (
        .ref_clk(ref_clk),
        .clk_en(clk_en),
        .async_in(raw_in),
        .sync_out(syn)
    );

    assign a_s = syn[30:16];
    assign ce_s = ~syn[15];
    assign oe_s = ~syn[14];
    assign we_s = ~syn[13];
    assign alarm_s = syn[12];
    assign dog_s = syn[11];
    assign w_s = syn[10:3];
    assign pw_s = rtcif_pkg::rtcif_power_t'(syn[2:0]);

    ////////////////////////////////////////////////////////////////////
    logic alarm_d_reg, dog_d_reg, alarm_rise, dog_rise;
    logic wr_d_reg, wr_stb;
    logic [3:0] rd_cnt_reg;
    logic rd_qual, rd_clear;
    logic is_read, is_write;
    rtcif_pkg::rtcif_pwr_state_t pwr_reg;
    logic supply_d_reg, power_up, power_down;

    assign is_read = ce_s & oe_s & ~we_s;
    assign is_write = ce_s & we_s;
    assign alarm_rise = alarm_s & ~alarm_d_reg;
    assign dog_rise = dog_s & ~dog_d_reg;
    assign wr_stb = is_write & ~wr_d_reg;
    assign power_up = pw_s.supply_ok & ~supply_d_reg;
    assign power_down = ~pw_s.supply_ok & supply_d_reg;

    // Edge detectors on synchronised levels
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            alarm_d_reg <= 1'b0;
            dog_d_reg <= 1'b0;
            wr_d_reg <= 1'b0;
            supply_d_reg <= 1'b0;
        end else if (clk_en) begin
            alarm_d_reg <= alarm_s;
            dog_d_reg <= dog_s;
            wr_d_reg <= is_write;
            supply_d_reg <= pw_s.supply_ok;
        end
    end

    // Read qualification: flag address stable in read mode
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_cnt_reg <= 4'h0;
        end else if (clk_en) begin
            if (is_read && a_s == rtcif_pkg::ADDR_EVENT_FLAGS) begin
                if (!rd_qual) rd_cnt_reg <= rd_cnt_reg + 4'h1;
            end else begin
                rd_cnt_reg <= 4'h0;
            end
        end
    end
    assign rd_qual = rd_cnt_reg >= rtcif_pkg::READ_CNT_MAX;
    // Clear when the qualified read ends (address moves or read drops)
    assign rd_clear = rd_qual &
        ~(is_read && a_s == rtcif_pkg::ADDR_EVENT_FLAGS);

    ////////////////////////////////////////////////////////////////////
    logic [7:0] alarm_en_reg, timeout_reg, mode_reg;
    logic alarm_flag_reg, dog_flag_reg, batt_low_reg;
    logic [7:0] flags_view;

    // Power-state tracking
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pwr_reg <= rtcif_pkg::PWR_DOWN;
        end else if (clk_en) begin
            case (pwr_reg)
                rtcif_pkg::PWR_DOWN: begin
                    if (power_up) pwr_reg <= rtcif_pkg::PWR_TEST;
                end
                rtcif_pkg::PWR_TEST: begin
                    pwr_reg <= pw_s.supply_ok ? rtcif_pkg::PWR_RUN
                                      : rtcif_pkg::PWR_DOWN;
                end
                rtcif_pkg::PWR_RUN: begin
                    if (power_down) pwr_reg <= rtcif_pkg::PWR_DOWN;
                end
                default: pwr_reg <= rtcif_pkg::PWR_DOWN;
            endcase
        end
    end

    // Battery test once per power-up, only on good supply
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            batt_low_reg <= 1'b0;
        end else if (clk_en) begin
            if (pwr_reg == rtcif_pkg::PWR_TEST && pw_s.supply_ok) begin
                batt_low_reg <= pw_s.battery_bad;
            end
        end
    end

    // Alarm enable register (both enables cleared at power-up and on a steered timeout, else held at power-down)
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            alarm_en_reg <= rtcif_pkg::BYTE_ZERO;
        end else if (clk_en) begin
            if (power_up) begin
                alarm_en_reg <= rtcif_pkg::BYTE_ZERO;
            end else if (dog_rise && timeout_reg[rtcif_pkg::STEER_BIT]) begin
                alarm_en_reg <= rtcif_pkg::BYTE_ZERO;
            end else if (power_down) begin
                alarm_en_reg <= alarm_en_reg;
            end else if (wr_stb && a_s == rtcif_pkg::ADDR_ALARM_EN) begin
                alarm_en_reg <= w_s;
            end
        end
    end

    // Timeout control register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            timeout_reg <= rtcif_pkg::BYTE_ZERO;
        end else if (clk_en) begin
            if (power_up || power_down) begin
                timeout_reg <= rtcif_pkg::BYTE_ZERO;
            end else if (dog_rise && timeout_reg[rtcif_pkg::STEER_BIT]) begin
                timeout_reg <= rtcif_pkg::BYTE_ZERO;
            end else if (wr_stb && a_s == rtcif_pkg::ADDR_TIMEOUT_CTRL) begin
                timeout_reg <= w_s;
            end
        end
    end

    // Mode register: write/read hold and frequency test bits
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mode_reg <= rtcif_pkg::BYTE_ZERO;
        end else if (clk_en) begin
            if (power_up || power_down) begin
                mode_reg <= rtcif_pkg::BYTE_ZERO;
            end else if (wr_stb && a_s == rtcif_pkg::ADDR_MODE_CTRL) begin
                mode_reg <= w_s;
            end
        end
    end

    // Event flags: set wins over the read clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            alarm_flag_reg <= 1'b0;
            dog_flag_reg <= 1'b0;
        end else if (clk_en) begin
            if (alarm_rise) alarm_flag_reg <= 1'b1;
            else if (rd_clear) alarm_flag_reg <= 1'b0;
            if (dog_rise && timeout_reg != rtcif_pkg::BYTE_ZERO)
                dog_flag_reg <= 1'b1;
            else if (rd_clear) dog_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic alarm_route, dog_route, irq_active, ftest_on;
    logic [15:0] ft_cnt_reg;
    logic ft_wave_reg;

    assign alarm_route = alarm_flag_reg &
        (alarm_en_reg[rtcif_pkg::ALARM_IRQ_EN_BIT] |
         alarm_en_reg[rtcif_pkg::ALARM_BACKUP_EN_BIT]);
    // A steered timeout clears the register, so a zero register never routes
    assign dog_route = dog_flag_reg & ~timeout_reg[rtcif_pkg::STEER_BIT] &
        (timeout_reg != rtcif_pkg::BYTE_ZERO);
    assign irq_active = alarm_route | dog_route;
    assign ftest_on = mode_reg[rtcif_pkg::FTEST_BIT];

    // Frequency test square wave
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ft_cnt_reg <= 16'h0000;
            ft_wave_reg <= 1'b0;
        end else if (clk_en) begin
            if (!ftest_on ||
                ft_cnt_reg == rtcif_pkg::FTEST_HALF_CYC - 16'h0001) begin
                ft_cnt_reg <= 16'h0000;
                ft_wave_reg <= ftest_on & ~ft_wave_reg;
            end else begin
                ft_cnt_reg <= ft_cnt_reg + 16'h0001;
            end
        end
    end

    // Open-drain pin: enable low pulls the wire low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            interrupt_test_pin_o <= 1'b0;
            interrupt_test_pin_oe_n <= 1'b1;
        end else if (clk_en) begin
            interrupt_test_pin_o <= 1'b0;
            if (irq_active) begin
                interrupt_test_pin_oe_n <= 1'b0;
            end else if (ftest_on) begin
                interrupt_test_pin_oe_n <= ft_wave_reg;
            end else begin
                interrupt_test_pin_oe_n <= 1'b1;
            end
        end
    end

    // Reset pulse request on steered timeout
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dog_reset_pulse <= 1'b0;
        end else if (clk_en) begin
            dog_reset_pulse <= dog_rise & timeout_reg[rtcif_pkg::STEER_BIT]
                & (timeout_reg != rtcif_pkg::BYTE_ZERO);
        end
    end

    // Register read port
    always_comb begin
        flags_view = rtcif_pkg::BYTE_ZERO;
        flags_view[rtcif_pkg::FLAG_DOG_BIT] = dog_flag_reg;
        flags_view[rtcif_pkg::FLAG_ALARM_BIT] = alarm_flag_reg;
        flags_view[rtcif_pkg::FLAG_BATT_BIT] = batt_low_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata <= rtcif_pkg::BYTE_ZERO;
            rdata_oe_n <= 1'b1;
        end else if (clk_en) begin
            rdata_oe_n <= ~is_read;
            if (a_s == rtcif_pkg::ADDR_EVENT_FLAGS) rdata <= flags_view;
            else if (a_s == rtcif_pkg::ADDR_ALARM_EN) rdata <= alarm_en_reg;
            else if (a_s == rtcif_pkg::ADDR_TIMEOUT_CTRL)
                rdata <= timeout_reg;
            else if (a_s == rtcif_pkg::ADDR_MODE_CTRL) rdata <= mode_reg;
            else rdata <= rtcif_pkg::BYTE_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin only driven when a routed event is pending or test is on
    pin_float_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && !irq_active && !ftest_on |=> interrupt_test_pin_oe_n)
        else $error("pin driven with nothing pending");
    // Routed interrupt pulls the pin
    irq_drive_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && irq_active |=> !interrupt_test_pin_oe_n)
        else $error("routed interrupt not driven");
    // Alarm event sets the flag
    alarm_set_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && alarm_rise |=> alarm_flag_reg)
        else $error("alarm flag not set");
    // Short read leaves flags intact
    short_read_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && !rd_qual && !alarm_rise && alarm_flag_reg
        |=> alarm_flag_reg)
        else $error("flag lost without qualified read");
    // Qualified read clears the timeout flag
    dog_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && rd_clear && !dog_rise |=> !dog_flag_reg)
        else $error("timeout flag not cleared");
    // Power-up zeroes the timeout register
    pwr_defaults_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && power_up |=> timeout_reg == rtcif_pkg::BYTE_ZERO)
        else $error("timeout register not cleared");
    // Power-down keeps alarm enables
    enable_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && power_down && !power_up && !dog_rise
        |=> $stable(alarm_en_reg))
        else $error("alarm enables lost at power-down");
    // Battery bit moves only in the test state
    batt_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        clk_en && pwr_reg != rtcif_pkg::PWR_TEST |=> $stable(batt_low_reg))
        else $error("battery flag changed outside test");
endmodule : rtcif_top

// ---- verification/rtcif_host_model.sv ----
// Host processor model on the asynchronous byte-wide register bus.
// Assumes calls start just after a rising edge of ref_clk.
`timescale 1ns/100ps
module rtcif_host_model (
    // Clock
    input wire logic ref_clk,
    // Bus driven by the host
    output logic [14:0] addr,
    output logic chip_en_n,
    output logic out_en_n,
    output logic write_en_n,
    output logic [7:0] wdata,
    // Read answer from the device
    input wire logic [7:0] rdata,
    input wire logic rdata_oe_n
);
    ////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        addr = 15'h0000;
        chip_en_n = 1'b1;
        out_en_n = 1'b1;
        write_en_n = 1'b1;
        wdata = 8'h00;
    end

    // Write: strobes held four edges so the synced copy sees them
    task automatic bus_write(input logic [14:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        chip_en_n = 1'b0;
        write_en_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        chip_en_n = 1'b1;
        write_en_n = 1'b1;
        addr = ~a;
        wdata = ~d;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : bus_write

    // Read: address held in read mode well past the qualify time
    task automatic bus_read(input logic [14:0] a, output logic [7:0] d,
                            output logic oe_n);
        addr = a;
        chip_en_n = 1'b0;
        out_en_n = 1'b0;
        repeat (5) @(posedge ref_clk);
        d = rdata;
        oe_n = rdata_oe_n;
        #1;
        chip_en_n = 1'b1;
        out_en_n = 1'b1;
        addr = ~a;
        repeat (5) @(posedge ref_clk);
        #1;
    endtask : bus_read

    // Read strobe of 10 ns between edges, shorter than the qualify time
    task automatic short_read(input logic [14:0] a);
        addr = a;
        chip_en_n = 1'b0;
        out_en_n = 1'b0;
        #10;
        chip_en_n = 1'b1;
        out_en_n = 1'b1;
        addr = ~a;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask : short_read
endmodule : rtcif_host_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the flag, pin routing and default logic.
// Assumes the host model and the design top are compiled before it.
`timescale 1ns/100ps
module tb_top;
    localparam logic [14:0] FLG = rtcif_pkg::ADDR_EVENT_FLAGS;
    localparam logic [14:0] AEN = rtcif_pkg::ADDR_ALARM_EN;
    localparam logic [14:0] TMO = rtcif_pkg::ADDR_TIMEOUT_CTRL;
    localparam logic [14:0] MOD = rtcif_pkg::ADDR_MODE_CTRL;
    localparam int CYC_LIMIT = 90000;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic alarm_event = 1'b0;
    logic dog_timeout = 1'b0;
    rtcif_pkg::rtcif_power_t power = 3'b110;
    logic [14:0] addr;
    logic chip_en_n, out_en_n, write_en_n, rdata_oe_n;
    logic pin_o, pin_oe_n, dog_rst;
    logic [7:0] wdata, rdata;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int dog_pulses = 0;

    ////////////////////////////////////////////////////////////////////
    // Clock, timeout and reset-pulse counter
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (dog_rst === 1'b1) dog_pulses++;
        if (cyc == CYC_LIMIT) begin
            err_total++;
            test_done();
        end
    end

    // Design and host model
    rtcif_top dut_u (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
        .addr(addr), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
        .write_en_n(write_en_n), .wdata(wdata), .rdata(rdata),
        .rdata_oe_n(rdata_oe_n), .alarm_event(alarm_event),
        .dog_timeout(dog_timeout), .power(power),
        .interrupt_test_pin_o(pin_o), .interrupt_test_pin_oe_n(pin_oe_n),
        .dog_reset_pulse(dog_rst));
    rtcif_host_model host_u (.ref_clk(ref_clk), .addr(addr),
        .chip_en_n(chip_en_n), .out_en_n(out_en_n),
        .write_en_n(write_en_n), .wdata(wdata), .rdata(rdata),
        .rdata_oe_n(rdata_oe_n));

    ////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic reg_is(input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] v;
        logic o;
        host_u.bus_read(a, v, o);
        chk("read data", exp, v);
        chk("read drive", 8'h00, {7'h00, o});
    endtask : reg_is

    task automatic pin_is(input logic exp_oe_n);
        chk("pin enable", {7'h00, exp_oe_n}, {7'h00, pin_oe_n});
        chk("pin level", 8'h00, {7'h00, pin_o});
    endtask : pin_is

    // Event line held four cycles, then time for sync and flag update
    task automatic fire(input logic dog);
        alarm_event = ~dog;
        dog_timeout = dog;
        tick(4);
        alarm_event = 1'b0;
        dog_timeout = 1'b0;
        tick(5);
    endtask : fire

    task automatic pwr_cycle(input logic bad_down, input logic bad_up);
        power.supply_ok = 1'b0;
        power.battery_bad = bad_down;
        tick(8);
        power.battery_bad = bad_up;
        tick(8);
        power.supply_ok = 1'b1;
        tick(8);
    endtask : pwr_cycle

    ////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_defaults();
        pin_is(1'b1);
        reg_is(FLG, 8'h00);
        reg_is(AEN, 8'h00);
        reg_is(TMO, 8'h00);
        reg_is(MOD, 8'h00);
        reg_is(15'h1234, 8'h00);
        host_u.bus_write(AEN, 8'h80);
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        tick(3);
        reg_is(AEN, 8'h00);
    endtask : t_defaults

    task automatic t_alarm();
        fire(1'b0);
        pin_is(1'b1);
        reg_is(FLG, 8'h40);
        reg_is(FLG, 8'h00);
        host_u.bus_write(AEN, 8'h80);
        reg_is(AEN, 8'h80);
        fire(1'b0);
        pin_is(1'b0);
        host_u.short_read(FLG);
        pin_is(1'b0);
        reg_is(FLG, 8'h40);
        pin_is(1'b1);
        host_u.bus_write(AEN, 8'h00);
    endtask : t_alarm

    task automatic t_dog();
        host_u.bus_write(TMO, 8'h0e);
        fire(1'b1);
        pin_is(1'b0);
        chk("reset pulses", 8'h00, 8'(dog_pulses));
        reg_is(FLG, 8'h80);
        reg_is(FLG, 8'h00);
        pin_is(1'b1);
        host_u.bus_write(TMO, 8'h8e);
        fire(1'b1);
        pin_is(1'b1);
        chk("reset pulses", 8'h01, 8'(dog_pulses));
        reg_is(FLG, 8'h80);
        host_u.bus_write(TMO, 8'h00);
    endtask : t_dog

    task automatic t_ftest();
        logic v;
        int n;
        host_u.bus_write(MOD, 8'h40);
        reg_is(MOD, 8'h40);
        v = pin_oe_n;
        n = 0;
        while (pin_oe_n === v && n < 25000) begin
            tick(1);
            n++;
        end
        chk("test toggle", 8'h01, {7'h00, n < 25000});
        host_u.bus_write(AEN, 8'h80);
        fire(1'b0);
        n = 0;
        repeat (25000) begin
            if (pin_oe_n !== 1'b0) n++;
            tick(1);
        end
        chk("test suppressed", 8'h00, 8'(n));
        host_u.bus_write(MOD, 8'h00);
        host_u.bus_write(AEN, 8'h00);
        reg_is(FLG, 8'h40);
        pin_is(1'b1);
    endtask : t_ftest

    task automatic t_power();
        host_u.bus_write(AEN, 8'ha0);
        host_u.bus_write(TMO, 8'h8e);
        host_u.bus_write(MOD, 8'h40);
        pwr_cycle(1'b1, 1'b1);
        reg_is(FLG, 8'h10);
        reg_is(FLG, 8'h10);
        reg_is(AEN, 8'h00);
        reg_is(TMO, 8'h00);
        reg_is(MOD, 8'h00);
        pwr_cycle(1'b0, 1'b1);
        reg_is(FLG, 8'h10);
        pwr_cycle(1'b0, 1'b0);
        reg_is(FLG, 8'h00);
        pwr_cycle(1'b1, 1'b0);
        reg_is(FLG, 8'h00);
    endtask : t_power

    // Verdict and end of run
    task automatic test_done();
        if (err_total == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        tick(3);
        t_defaults();
        t_alarm();
        t_dog();
        t_ftest();
        t_power();
        test_done();
    end
endmodule : tb_top
